/* pkg/ccsr_defines.vh */
`ifndef CCSR_DEFINES_VH
`define CCSR_DEFINES_VH
// Bus address bytes (7-bit address with read/write bit)
`define CCSR_ADDR_BASE 7'h26
`define CCSR_WR_LOW 8'h4C
`define CCSR_RD_LOW 8'h4D
`define CCSR_WR_HIGH 8'h4E
`define CCSR_RD_HIGH 8'h4F
// Register indexes
`define CCSR_IDX_INCTL 8'h00
`define CCSR_IDX_LOOP 8'h01
`define CCSR_IDX_FBLO 8'h02
`define CCSR_IDX_FBHI 8'h03
`define CCSR_IDX_POFS 8'h04
`define CCSR_IDX_PACTL 8'h05
`define CCSR_IDX_OEN 8'h06
`define CCSR_IDX_OSC 8'h07
`define CCSR_IDX_SRST 8'h08
`define CCSR_IDX_VER 8'h10
`define CCSR_IDX_REV 8'h11
`define CCSR_IDX_STAT 8'h12
// Reset values
`define CCSR_RST_INCTL 8'h41
`define CCSR_RST_LOOP 8'h00
`define CCSR_RST_FBLO 8'hFF
`define CCSR_RST_FBHI 8'h0F
`define CCSR_RST_POFS 8'h80
`define CCSR_RST_PACTL 8'h03
`define CCSR_RST_OEN 8'h1F
`define CCSR_RST_OSC 8'h80
// Writable bit masks
`define CCSR_MSK_LOOP 8'h37
`define CCSR_MSK_FBHI 8'h0F
`define CCSR_MSK_POFS 8'hBF
// Soft reset codes
`define CCSR_SRST_PA_CODE 4'hA
`define CCSR_SRST_PLL_CODE 4'h5
// Feedback and oscillator modulus offsets
`define CCSR_FB_ADD 13'h0008
`define CCSR_OSC_ADD 8'h02
// Field positions
`define CCSR_B_PUMP 0
`define CCSR_B_PPOL 1
`define CCSR_B_REFPOL 2
`define CCSR_B_FBPOL 3
`define CCSR_B_FBSEL 4
`define CCSR_B_FUNC 5
`define CCSR_B_PLLREP 6
`define CCSR_B_PHREP 7
`endif

/* src/ccsr_pin_sync.v */
`timescale 1ns/100ps
// Two-flop synchroniser plus a one-cycle-delayed previous value for edge detection
module ccsr_pin_sync (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Raw pin and synchronised level
	input wire pin_in,
	output reg level_q,
	output reg prev_q
);
	reg meta_q; // First stage, read only by level_q

	// Synchronise, then keep one cycle of history
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b1;
			level_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= pin_in;
			level_q <= meta_q;
			prev_q <= level_q;
		end
	end
endmodule

/* src/ccsr_regs.v */
`timescale 1ns/100ps
`include "ccsr_defines.vh"
// What this block does
// (RULE_01) Answers address set by select pin
// (RULE_02) Bit 0 keeps charge pump on
// (RULE_03) Bit 1 sets pump pin polarity
// (RULE_04) Bit 2 picks reference trigger edge
// (RULE_05) Bit 3 picks external feedback edge
// (RULE_06) Bit 4 picks feedback source
// (RULE_07) Bit 5 picks function output source
// (RULE_08) Bits 6-7 gate lock status reporting
// (RULE_09) Pump gain code, one-hot gain out
// (RULE_10) Post-scaler code divides by 2..16
// (RULE_11) Twelve-bit feedback value in two registers
// (RULE_12) Loop settings double-buffered, loaded on PLL reset
// (RULE_13) Phase control double-buffered, loaded on phase reset
// (RULE_14) Low nibble A resets phase logic
// (RULE_15) High nibble 5 resets PLL
// (RULE_16) Phase offset and filter select
// (RULE_17) Delay resolution code, reset three
// (RULE_18) Five output enables, zero is high-Z
// (RULE_19) Bit 5 picks full or half clock
// (RULE_20) Delayed single clock scaler 1..8
// (RULE_21) Oscillator modulus, reserved select bit
// (RULE_22) Status register shows two lock bits
// (RULE_23) Feedback modulus is value plus eight
// (RULE_24) Oscillator modulus is value plus two
// (RULE_25) Write: address, index, data, acked, MSB first
// (RULE_26) Upper phase control bits show revision
// (RULE_27) Reserved and unmapped read zero
// (RULE_28) Read after index write, index increments
module ccsr_regs (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Two-wire serial port
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_q,
	output reg sda_oe_q,
	input wire address_select_pin,
	// Lock inputs from analog side
	input wire pll_locked_in,
	input wire phase_locked_flag,
	// Input control fields
	output reg pump_always_on_q,
	output reg pump_pin_polarity_q,
	output reg ref_edge_falling_q,
	output reg fb_edge_negative_q,
	output reg fb_external_q,
	output reg func_external_q,
	output reg pll_lock_report_enable_q,
	output reg phase_lock_report_enable_q,
	// Working loop settings
	output reg [7:0] pump_gain_q,
	output reg [1:0] post_scaler_code_q,
	output reg [4:0] post_scaler_div_q,
	output reg [11:0] feedback_value_q,
	output reg [12:0] feedback_modulus_q,
	output reg pll_reset_q,
	// Phase adjust settings
	output reg [5:0] phase_offset_steps_q,
	output reg filter_internal_q,
	output reg [1:0] delay_resolution_code_q,
	output reg phase_reset_q,
	// Output enables and scalers
	output reg [4:0] output_enable_q,
	output reg clock_source_select_q,
	output reg [3:0] delayed_clock_div_q,
	// Oscillator divider
	output reg [7:0] osc_modulus_q,
	output reg osc_input_select_q,
	// Status pin reporting
	output reg lock_report_q
);
	// Arbitrary identity values
	parameter [7:0] VERSION_ID = 8'hA5;
	parameter [7:0] REVISION_ID = 8'h3C;
	parameter [5:0] MASK_REV_ID = 6'h3F;

	// Bus states, one-hot
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_ADDR = 6'h02;
	localparam [5:0] S_ACK = 6'h04;
	localparam [5:0] S_WDAT = 6'h08;
	localparam [5:0] S_RDAT = 6'h10;
	localparam [5:0] S_RACK = 6'h20;

	// Shift a bit into a byte, MSB first
	function [7:0] shift_in;
		input [7:0] cur;
		input bitv;
		begin
			shift_in = {cur[6:0], bitv};
		end
	endfunction

	// Power-of-two decode
	function [7:0] pow2;
		input [2:0] code;
		begin
			pow2 = 8'h01 << code;
		end
	endfunction

	wire scl_s, scl_p, sda_s, sda_p;
	ccsr_pin_sync u_scl (.clk(clk), .nrst(nrst), .pin_in(scl_in), .level_q(scl_s), .prev_q(scl_p));
	ccsr_pin_sync u_sda (.clk(clk), .nrst(nrst), .pin_in(sda_in), .level_q(sda_s), .prev_q(sda_p));

	wire scl_rise = scl_s & ~scl_p; // Sample point
	wire scl_fall = ~scl_s & scl_p; // Drive point
	wire start_c = scl_s & scl_p & sda_p & ~sda_s; // Start or repeated start
	wire stop_c = scl_s & scl_p & ~sda_p & sda_s; // Stop

	reg [5:0] state_q;
	reg [7:0] shift_q; // Receive or transmit byte
	reg [3:0] bitcnt_q; // Bits done in this byte
	reg is_read_q; // Current transfer direction
	reg have_index_q; // Index byte received
	reg ack_me_q; // This byte is acknowledged
	reg [7:0] index_q; // Register pointer
	reg [7:0] loop_hold_q, fblo_hold_q, fbhi_hold_q, pactl_hold_q; // Holding copies
	reg [7:0] inctl_q, pofs_q, oen_q, osc_q;
	reg rev_armed_q; // Upper phase bits written with all ones
	reg [5:0] rev_bits_q;

	// Read mux; reserved and unmapped read zero [RULE_27]
	function [7:0] rd_mux;
		input [7:0] idx;
		begin
			case (idx)
				`CCSR_IDX_INCTL: rd_mux = inctl_q;
				`CCSR_IDX_LOOP: rd_mux = loop_hold_q;
				`CCSR_IDX_FBLO: rd_mux = fblo_hold_q;
				`CCSR_IDX_FBHI: rd_mux = fbhi_hold_q; // [RULE_11]
				`CCSR_IDX_POFS: rd_mux = pofs_q;
				`CCSR_IDX_PACTL: rd_mux = {rev_bits_q, pactl_hold_q[1:0]}; // [RULE_26]
				`CCSR_IDX_OEN: rd_mux = oen_q;
				`CCSR_IDX_OSC: rd_mux = osc_q;
				`CCSR_IDX_VER: rd_mux = VERSION_ID;
				`CCSR_IDX_REV: rd_mux = REVISION_ID;
				`CCSR_IDX_STAT: rd_mux = {6'h00, pll_locked_in, phase_locked_flag}; // [RULE_22]
				default: rd_mux = 8'h00;
			endcase
		end
	endfunction

	wire [7:0] rx_byte = shift_in(shift_q, sda_s);
	wire [7:0] rd_byte = rd_mux(index_q); // Byte to send from the current index
	wire byte_done = scl_rise & (bitcnt_q == 4'h7);
	// Select pin supplies the low address bit
	wire addr_hit = (rx_byte[7:1] == (`CCSR_ADDR_BASE | {6'h00, address_select_pin})); // [RULE_01]
	wire data_wr = (state_q == S_WDAT) & byte_done & have_index_q; // [RULE_25]
	wire srst_wr = data_wr & (index_q == `CCSR_IDX_SRST);
	wire pll_go = srst_wr & (rx_byte[7:4] == `CCSR_SRST_PLL_CODE); // [RULE_15]
	wire pa_go = srst_wr & (rx_byte[3:0] == `CCSR_SRST_PA_CODE); // [RULE_14]

	// Serial slave state machine
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			shift_q <= 8'h00;
			bitcnt_q <= 4'h0;
			is_read_q <= 1'b0;
			have_index_q <= 1'b0;
			ack_me_q <= 1'b0;
			index_q <= 8'h00;
			sda_out_q <= 1'b1;
			sda_oe_q <= 1'b0;
		end else if (start_c) begin
			// Start resets the byte counter
			state_q <= S_ADDR;
			bitcnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_c) begin
			state_q <= S_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				S_ADDR, S_WDAT: begin
					// Receive a byte MSB first
					if (scl_rise) begin
						shift_q <= rx_byte;
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					if (byte_done) begin
						if (state_q == S_ADDR) begin
							ack_me_q <= addr_hit;
							is_read_q <= rx_byte[0];
							have_index_q <= 1'b0;
						end else if (!have_index_q) begin
							index_q <= rx_byte; // [RULE_28]
							have_index_q <= 1'b1;
							ack_me_q <= 1'b1;
						end else begin
							index_q <= index_q + 8'h01; // [RULE_25]
							ack_me_q <= 1'b1;
						end
						state_q <= (state_q == S_ADDR && !addr_hit) ? S_IDLE : S_ACK;
					end
				end
				S_ACK: begin
					// Drive acknowledge low across the ninth clock
					if (scl_fall && !sda_oe_q) begin
						sda_oe_q <= ack_me_q;
						sda_out_q <= 1'b0;
					end else if (scl_fall) begin
						bitcnt_q <= 4'h0;
						if (is_read_q) begin
							shift_q <= rd_byte;
							sda_out_q <= rd_byte[7];
							sda_oe_q <= 1'b1;
							state_q <= S_RDAT;
						end else begin
							sda_oe_q <= 1'b0;
							state_q <= S_WDAT;
						end
					end
				end
				S_RDAT: begin
					// Shift out MSB first on falling clock [RULE_28]
					if (scl_fall) begin
						if (bitcnt_q == 4'h7) begin
							sda_oe_q <= 1'b0;
							state_q <= S_RACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sda_out_q <= shift_q[6];
						end
						bitcnt_q <= bitcnt_q + 4'h1;
					end
				end
				S_RACK: begin
					// Host acknowledge continues, nack ends
					if (scl_rise) begin
						index_q <= index_q + 8'h01; // [RULE_28]
						if (sda_s) begin
							state_q <= S_IDLE;
						end
					end else if (scl_fall) begin
						// Next byte goes out only while the clock is low
						bitcnt_q <= 4'h0;
						shift_q <= rd_byte;
						sda_out_q <= rd_byte[7];
						sda_oe_q <= 1'b1;
						state_q <= S_RDAT;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Register writes; read-only and unmapped writes are dropped [RULE_27]
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			inctl_q <= `CCSR_RST_INCTL;
			loop_hold_q <= `CCSR_RST_LOOP;
			fblo_hold_q <= `CCSR_RST_FBLO;
			fbhi_hold_q <= `CCSR_RST_FBHI;
			pofs_q <= `CCSR_RST_POFS;
			pactl_hold_q <= `CCSR_RST_PACTL;
			oen_q <= `CCSR_RST_OEN;
			osc_q <= `CCSR_RST_OSC;
			rev_armed_q <= 1'b0;
		end else if (data_wr) begin
			case (index_q)
				`CCSR_IDX_INCTL: inctl_q <= rx_byte;
				`CCSR_IDX_LOOP: loop_hold_q <= rx_byte & `CCSR_MSK_LOOP; // [RULE_12]
				`CCSR_IDX_FBLO: fblo_hold_q <= rx_byte; // [RULE_12]
				`CCSR_IDX_FBHI: fbhi_hold_q <= rx_byte & `CCSR_MSK_FBHI; // [RULE_11]
				`CCSR_IDX_POFS: pofs_q <= rx_byte & `CCSR_MSK_POFS; // [RULE_16]
				`CCSR_IDX_PACTL: begin
					pactl_hold_q <= rx_byte; // [RULE_13]
					// Stays armed once the all-ones write has been seen
					rev_armed_q <= rev_armed_q | (rx_byte[7:2] == 6'h3F); // [RULE_26]
				end
				`CCSR_IDX_OEN: oen_q <= rx_byte;
				`CCSR_IDX_OSC: osc_q <= rx_byte; // [RULE_21]
				default: rev_armed_q <= rev_armed_q;
			endcase
		end
	end

	// Revision bits read zero until armed
	always @* begin
		rev_bits_q = rev_armed_q ? MASK_REV_ID : 6'h00;
	end

	// Working copies and decoded outputs
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pump_always_on_q <= 1'b1;
			pump_pin_polarity_q <= 1'b0;
			ref_edge_falling_q <= 1'b0;
			fb_edge_negative_q <= 1'b0;
			fb_external_q <= 1'b0;
			func_external_q <= 1'b0;
			pll_lock_report_enable_q <= 1'b1;
			phase_lock_report_enable_q <= 1'b0;
			pump_gain_q <= 8'h01;
			post_scaler_code_q <= 2'h0;
			post_scaler_div_q <= 5'h02;
			feedback_value_q <= 12'hFFF;
			feedback_modulus_q <= 13'h1007;
			pll_reset_q <= 1'b0;
			phase_offset_steps_q <= 6'h00;
			filter_internal_q <= 1'b1;
			delay_resolution_code_q <= 2'h3;
			phase_reset_q <= 1'b0;
			output_enable_q <= 5'h1F;
			clock_source_select_q <= 1'b0;
			delayed_clock_div_q <= 4'h1;
			osc_modulus_q <= 8'h02;
			osc_input_select_q <= 1'b1;
			lock_report_q <= 1'b0;
		end else begin
			pump_always_on_q <= inctl_q[`CCSR_B_PUMP]; // [RULE_02]
			pump_pin_polarity_q <= inctl_q[`CCSR_B_PPOL]; // [RULE_03]
			ref_edge_falling_q <= inctl_q[`CCSR_B_REFPOL]; // [RULE_04]
			fb_edge_negative_q <= inctl_q[`CCSR_B_FBPOL] & inctl_q[`CCSR_B_FBSEL]; // [RULE_05]
			fb_external_q <= inctl_q[`CCSR_B_FBSEL]; // [RULE_06]
			func_external_q <= inctl_q[`CCSR_B_FUNC]; // [RULE_07]
			pll_lock_report_enable_q <= inctl_q[`CCSR_B_PLLREP];
			phase_lock_report_enable_q <= inctl_q[`CCSR_B_PHREP];
			// Gated lock report [RULE_08]
			lock_report_q <= (inctl_q[`CCSR_B_PLLREP] & pll_locked_in) |
				(inctl_q[`CCSR_B_PHREP] & phase_locked_flag);
			pll_reset_q <= pll_go; // [RULE_15]
			phase_reset_q <= pa_go; // [RULE_14]
			if (pll_go) begin
				pump_gain_q <= pow2(loop_hold_q[2:0]); // [RULE_09]
				post_scaler_code_q <= loop_hold_q[5:4];
				post_scaler_div_q <= {3'h0, 2'h2} << loop_hold_q[5:4]; // [RULE_10]
				feedback_value_q <= {fbhi_hold_q[3:0], fblo_hold_q}; // [RULE_12]
				feedback_modulus_q <= {1'b0, fbhi_hold_q[3:0], fblo_hold_q} + `CCSR_FB_ADD; // [RULE_23]
			end
			if (pa_go) begin
				delay_resolution_code_q <= pactl_hold_q[1:0]; // [RULE_13] [RULE_17]
			end
			phase_offset_steps_q <= pofs_q[5:0]; // [RULE_16]
			filter_internal_q <= pofs_q[7];
			output_enable_q <= oen_q[4:0]; // [RULE_18]
			clock_source_select_q <= oen_q[5]; // [RULE_19]
			delayed_clock_div_q <= 4'h1 << oen_q[7:6]; // [RULE_20]
			osc_modulus_q <= {1'b0, osc_q[6:0]} + `CCSR_OSC_ADD; // [RULE_24]
			osc_input_select_q <= osc_q[7]; // [RULE_21]
		end
	end
endmodule

/* dv/ccsr_regs_properties.sv */
`timescale 1ns/100ps
// Port-level checks on the configuration bank
module ccsr_regs_chk (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Bus and lock pins
	input wire scl_in,
	input wire sda_out_q,
	input wire sda_oe_q,
	input wire pll_locked_in,
	input wire phase_locked_flag,
	// Watched fields
	input wire pll_lock_report_enable_q,
	input wire phase_lock_report_enable_q,
	input wire [7:0] pump_gain_q,
	input wire [1:0] post_scaler_code_q,
	input wire [4:0] post_scaler_div_q,
	input wire [11:0] feedback_value_q,
	input wire [12:0] feedback_modulus_q,
	input wire pll_reset_q,
	input wire phase_reset_q,
	input wire [1:0] delay_resolution_code_q,
	input wire [7:0] osc_modulus_q,
	input wire lock_report_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Lock inputs and enables held stable for six cycles, past the lock report register
	sequence s_quiet;
		($stable(pll_locked_in) && $stable(phase_locked_flag)
		&& $stable(pll_lock_report_enable_q) && $stable(phase_lock_report_enable_q))[*6];
	endsequence
	// Strobe high for exactly one cycle
	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence
	property p_scale; post_scaler_div_q == (5'h02 << post_scaler_code_q); endproperty
	property p_fbmod; feedback_modulus_q == {1'b0, feedback_value_q} + 13'h0008; endproperty
	property p_osc; osc_modulus_q >= 8'h02 && osc_modulus_q <= 8'h81; endproperty
	property p_gain; $onehot(pump_gain_q); endproperty
	property p_lock; s_quiet |-> lock_report_q == ((pll_lock_report_enable_q && pll_locked_in)
		|| (phase_lock_report_enable_q && phase_locked_flag)); endproperty
	property p_pll; pll_reset_q |-> s_pulse(pll_reset_q); endproperty
	property p_pa; phase_reset_q |-> s_pulse(phase_reset_q); endproperty
	property p_loop; ($changed(feedback_value_q) || $changed(pump_gain_q)
		|| $changed(post_scaler_code_q)) |-> (pll_reset_q || $past(pll_reset_q)); endproperty
	property p_res; $changed(delay_resolution_code_q) |-> (phase_reset_q || $past(phase_reset_q));
	endproperty
	property p_sda; ($changed(sda_oe_q) || (sda_oe_q && $changed(sda_out_q))) |-> !scl_in;
	endproperty
	property p_ack; $rose(sda_oe_q) |=> sda_oe_q [*8]; endproperty
	a_scale: assert property (p_scale) else $error("post scaler divide wrong");
	a_fbmod: assert property (p_fbmod) else $error("feedback modulus wrong");
	a_osc: assert property (p_osc) else $error("oscillator modulus out of range");
	a_gain: assert property (p_gain) else $error("pump gain not one-hot");
	a_lock: assert property (p_lock) else $error("lock report wrong");
	a_pll: assert property (p_pll) else $error("loop reset strobe too long");
	a_pa: assert property (p_pa) else $error("phase reset strobe too long");
	a_loop: assert property (p_loop) else $error("loop copy moved alone");
	a_res: assert property (p_res) else $error("resolution moved alone");
	a_sda: assert property (p_sda) else $error("data moved with clock high");
	a_ack: assert property (p_ack) else $error("data drive too short");
endmodule
bind ccsr_regs ccsr_regs_chk u_chk (.clk, .nrst, .scl_in, .sda_out_q, .sda_oe_q, .pll_locked_in,
	.phase_locked_flag, .pll_lock_report_enable_q, .phase_lock_report_enable_q, .pump_gain_q,
	.post_scaler_code_q, .post_scaler_div_q, .feedback_value_q, .feedback_modulus_q,
	.pll_reset_q, .phase_reset_q, .delay_resolution_code_q, .osc_modulus_q, .lock_report_q);

/* dv/ccsr_i2c_host.sv */
`timescale 1ns/100ps
// Bus host: drives clock and open-drain data, released data is high
module ccsr_i2c_host (
	// Clock
	input wire clk,
	// Resolved data line
	input wire sda_line,
	// Host drives
	output reg scl,
	output reg sda
);
	// Idle bus
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Wait whole clocks
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bit: data moves only with clock low, sampled mid-high
	task automatic xbit(input logic b, output logic r);
		sda <= b;
		hold(8);
		scl <= 1'b1;
		hold(6);
		r = sda_line;
		hold(6);
		scl <= 1'b0;
		hold(2);
	endtask
	// Start or repeated start
	task automatic start;
		sda <= 1'b1;
		hold(8);
		scl <= 1'b1;
		hold(8);
		sda <= 1'b0;
		hold(8);
		scl <= 1'b0;
		hold(2);
	endtask
	// Stop, clock left standing high
	task automatic stop;
		sda <= 1'b0;
		hold(8);
		scl <= 1'b1;
		hold(8);
		sda <= 1'b1;
		hold(8);
	endtask
	// Byte out MSB first, ninth bit a; returns sampled bits and ninth bit
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		xbit(a, r);
	endtask
endmodule

/* dv/clock_synth_config_regs_tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the configuration bank
module clock_synth_config_regs_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sel = 1'b0;
	logic pll_lk = 1'b0;
	logic ph_lk = 1'b0;
	int checks = 0;
	int error_cnt = 0;
	wire scl, sda_h, sda_out, sda_oe;
	wire [7:0] inctl_o, gain_o, osc_o;
	wire [11:0] fbv_o;
	wire [5:0] pofs_o;
	wire [4:0] oen_o;
	wire [3:0] dcd_o;
	wire [1:0] psc_o, res_o;
	wire fil_o, cks_o, osel_o, lock_o;
	// Open-drain data line with pull-up
	wire sda_line = sda_h & ~(sda_oe & ~sda_out);
	// Model: readback copies, masks, working copies
	logic [7:0] hr[0:7];
	logic [7:0] msk[0:7] = '{8'hFF, 8'h37, 8'hFF, 8'h0F, 8'hBF, 8'h03, 8'hFF, 8'hFF};
	logic [7:0] srst[0:3] = '{8'h3A, 8'h5C, 8'h5A, 8'hA5};
	logic [7:0] wk_loop, wk_fbl, wk_fbh;
	logic [1:0] wk_res;
	logic armed;
	logic [7:0] dq[$];

	// Free-running clock
	always #5 clk = ~clk;

	ccsr_i2c_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
	ccsr_regs dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out_q(sda_out),
		.sda_oe_q(sda_oe), .address_select_pin(sel), .pll_locked_in(pll_lk),
		.phase_locked_flag(ph_lk), .pump_always_on_q(inctl_o[0]), .pump_pin_polarity_q(inctl_o[1]),
		.ref_edge_falling_q(inctl_o[2]), .fb_edge_negative_q(inctl_o[3]), .fb_external_q(inctl_o[4]),
		.func_external_q(inctl_o[5]), .pll_lock_report_enable_q(inctl_o[6]),
		.phase_lock_report_enable_q(inctl_o[7]), .pump_gain_q(gain_o), .post_scaler_code_q(psc_o),
		.post_scaler_div_q(), .feedback_value_q(fbv_o), .feedback_modulus_q(), .pll_reset_q(),
		.phase_offset_steps_q(pofs_o), .filter_internal_q(fil_o), .delay_resolution_code_q(res_o),
		.phase_reset_q(), .output_enable_q(oen_o), .clock_source_select_q(cks_o),
		.delayed_clock_div_q(dcd_o), .osc_modulus_q(osc_o), .osc_input_select_q(osel_o),
		.lock_report_q(lock_o));

	// Power-up state of the model
	task automatic mreset;
		hr = '{8'h41, 8'h00, 8'hFF, 8'h0F, 8'h80, 8'h03, 8'h1F, 8'h80};
		wk_loop = 8'h00;
		wk_fbl = 8'hFF;
		wk_fbh = 8'h0F;
		wk_res = 2'h3;
		armed = 1'b0;
	endtask
	// Model write: masked holding copies, soft reset loads working copies
	task automatic mwr(input int i, input logic [7:0] d);
		if (i < 8) hr[i] = d & msk[i];
		if (i == 5 && d[7:2] == 6'h3F) armed = 1'b1;
		if (i == 8 && d[3:0] == 4'hA) wk_res = hr[5][1:0];
		if (i == 8 && d[7:4] == 4'h5) begin
			wk_loop = hr[1];
			wk_fbl = hr[2];
			wk_fbh = hr[3];
		end
	endtask
	// Model readback
	function automatic logic [7:0] mrd(input int i);
		case (i)
			5: return {armed ? 6'h3F : 6'h00, hr[5][1:0]};
			16: return 8'hA5;
			17: return 8'h3C;
			18: return {6'h00, pll_lk, ph_lk};
			default: return (i < 8) ? hr[i] : 8'h00;
		endcase
	endfunction
	// Field comparison
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Bus byte or acknowledge comparison
	task automatic cmp_bus(input logic [7:0] g, input logic [7:0] e);
		cmp({24'h0, g}, {24'h0, e});
	endtask
	// Connected field outputs except lock_o against the model
	task automatic chk_fields;
		cmp(inctl_o, {hr[0][7:4], hr[0][3] & hr[0][4], hr[0][2:0]});
		cmp(gain_o, 8'h01 << wk_loop[2:0]);
		cmp(psc_o, wk_loop[5:4]);
		cmp(fbv_o, {wk_fbh[3:0], wk_fbl});
		cmp({fil_o, pofs_o}, {hr[4][7], hr[4][5:0]});
		cmp(res_o, wk_res);
		cmp({dcd_o, cks_o, oen_o}, {4'h1 << hr[6][7:6], hr[6][5:0]});
		cmp({osel_o, osc_o}, {hr[7][7], {1'b0, hr[7][6:0]} + 8'h02});
	endtask
	// Sequential write; ok low sends the other address and expects no answer
	task automatic wr(input logic ok, input int idx, input logic [7:0] d[$]);
		logic [7:0] q;
		logic r;
		host.start;
		host.xbyte((sel ^ ~ok) ? 8'h4E : 8'h4C, 1'b1, q, r);
		cmp_bus({7'h00, r}, {7'h00, ~ok});
		if (ok) begin
			host.xbyte(idx[7:0], 1'b1, q, r);
			foreach (d[i]) begin
				host.xbyte(d[i], 1'b1, q, r);
				cmp_bus({7'h00, r}, 8'h00);
				mwr(idx + i, d[i]);
			end
		end
		host.stop;
	endtask
	// Index write, repeated start, n bytes read
	task automatic rd(input int idx, input int n);
		logic [7:0] q;
		logic r;
		host.start;
		host.xbyte(sel ? 8'h4E : 8'h4C, 1'b1, q, r);
		host.xbyte(idx[7:0], 1'b1, q, r);
		host.start;
		host.xbyte(sel ? 8'h4F : 8'h4D, 1'b1, q, r);
		cmp_bus({7'h00, r}, 8'h00);
		for (int i = 0; i < n; i++) begin
			host.xbyte(8'hFF, i == n - 1, q, r);
			cmp_bus(q, mrd(idx + i));
		end
		host.stop;
	endtask
	// Counts and verdict
	task automatic complete_run;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		complete_run;
	end
	// Main sequence
	initial begin
		void'($urandom(61));
		mreset;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		host.hold(4);
		chk_fields;
		rd(0, 20);
		$display("test reset values done");
		repeat (8) dq.push_back(8'($urandom));
		wr(1'b1, 0, dq);
		rd(0, 8);
		chk_fields;
		$display("test burst write done");
		for (int k = 0; k < 4; k++) begin
			dq = {};
			repeat (5) dq.push_back(8'($urandom));
			wr(1'b1, 1, dq);
			dq = {srst[k]};
			wr(1'b1, 8, dq);
			chk_fields;
		end
		$display("test soft reset done");
		dq = {8'hFC | 8'($urandom)};
		wr(1'b1, 5, dq);
		rd(5, 1);
		dq = {8'($urandom), 8'($urandom), 8'($urandom)};
		wr(1'b1, 16, dq);
		rd(16, 3);
		$display("test revision and read-only done");
		for (int p = 0; p < 2; p++) begin
			sel <= p[0];
			host.hold(4);
			wr(1'b0, 6, dq);
			dq = {8'($urandom), 8'($urandom)};
			wr(1'b1, 6, dq);
			rd(6, 2);
		end
		$display("test address select done");
		for (int m = 0; m < 4; m++) begin
			pll_lk <= m[0];
			ph_lk <= m[1];
			dq = {8'($urandom)};
			wr(1'b1, 0, dq);
			host.hold(10);
			cmp(lock_o, (hr[0][6] & pll_lk) | (hr[0][7] & ph_lk));
			rd(18, 1);
			chk_fields;
		end
		$display("test lock status done");
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		mreset;
		nrst <= 1'b1;
		host.hold(4);
		chk_fields;
		rd(0, 8);
		$display("test second reset done");
		complete_run;
	end
endmodule
